// *** debug_pin_enable_latch_tb.sv ***
// self-checking bench for the debug pin enable latch
// assumes dple_top, dple_probe and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "dple_consts.vh"
module debug_pin_enable_latch_tb;
   logic i_clock, i_rst, rd, wr, lock_n, halted, dp_out, dp_oe, gp_clk, go;
   logic [7:0] addr, word, seen;
   logic [31:0] wdata, rnd, rdata;
   logic wreq, dio_oe, dio_o, clk_oe, clk_o, pu, pd, cpu, cpd, dp_rise, dp_din;
   logic wd_run, gt_run, ta_run, p_run, gp_cin, p_clk, p_dio, p_oe, dp_clk;
   logic [31:0] expq[$];
   logic bitq[$];
   int mismatches, checks_done, cyc;
   wire dio_w = dio_oe ? dio_o : p_oe ? p_dio : pu;
   wire clk_w = clk_oe ? clk_o : p_clk;
   dple_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_debug_lock_pin_n(lock_n),
      .i_swd_clk_pin(clk_w), .i_swd_dio_pin(dio_w), .o_swd_dio_pin(dio_o),
      .o_swd_dio_oe(dio_oe), .o_swd_clk_pin(clk_o), .o_swd_clk_oe(clk_oe),
      .o_clk_pull_up(cpu), .o_clk_pull_down(cpd), .o_dio_pull_up(pu), .o_dio_pull_down(pd),
      .o_dp_clk(dp_clk), .o_dp_clk_rise(dp_rise), .o_dp_dio_in(dp_din), .i_dp_dio_out(dp_out),
      .i_dp_dio_oe(dp_oe), .i_gp_clk_out(gp_clk), .i_gp_dio_out(rnd[3]),
      .o_gp_clk_in(gp_cin), .o_gp_dio_in(), .o_system_reset(), .i_core_halted(halted),
      .o_watchdog_timer_run(wd_run), .o_general_timer_run(gt_run),
      .o_sixteen_bit_timer_a_run(ta_run), .o_peripheral_run(p_run));
   dple_probe u_probe (.i_go(go), .i_word(word), .i_dio(dio_w), .o_clk(p_clk),
      .o_dio(p_dio), .o_dio_oe(p_oe), .o_seen(seen));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks_done++;
      if (seen_v !== exp_v) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic results;
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] e);
      int n;
      n = 0;
      if (!w) expq.push_back(e);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      @(posedge i_clock);
      while (wreq !== 1'b0 && n < 200) begin
         @(posedge i_clock);
         n++;
      end
      if (n == 200) mismatches++;
      rd <= 0;
      wr <= 0;
      @(posedge i_clock);
   endtask
   task automatic pin_rst(input logic l);
      lock_n <= l;
      i_rst <= 1;
      repeat (2) @(posedge i_clock);
      i_rst <= 0;
      repeat (10) @(posedge i_clock);
   endtask
   initial begin
      i_clock = 0;
      forever #2.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         results;
      end
      if (rd && !wreq && expq.size() > 0) chk(rdata, expq.pop_front());
      if (dp_rise && bitq.size() > 0) chk(dp_din, bitq.pop_front());
   end
   initial begin
      {rd, wr, halted, dp_out, dp_oe, gp_clk, go} = 0;
      {i_rst, lock_n, addr, wdata, word, mismatches, checks_done, cyc} = 0;
      rnd = 32'hB75C96D3;
      pin_rst(1);
      chk({clk_oe, cpd, cpu, pd, pu}, 5'b01001);
      bus(0, `DPLE_OFF_CLK_PORT, 0, `DPLE_CLK_PORT_RST);
      bus(0, `DPLE_OFF_DIO_PORT, 0, `DPLE_DIO_PORT_RST);
      bus(1, `DPLE_OFF_MONITOR, 32'hFFFFFFFF, 0);
      bus(0, `DPLE_OFF_MONITOR, 0, 0);
      bus(0, 8'h40, 0, `DPLE_RD_DEFAULT);
      bus(1, `DPLE_OFF_CLK_PORT, 32'h16, 0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         gp_clk <= rnd[0];
         repeat (4) @(posedge i_clock);
         chk({clk_oe, clk_o}, {1'b1, rnd[0]});
      end
      bus(1, `DPLE_OFF_CONTROL, 32'h1, 0);
      repeat (12) @(posedge i_clock);
      bus(0, `DPLE_OFF_CLK_PORT, 0, `DPLE_CLK_PORT_RST);
      word = rnd[7:0];
      for (int i = 0; i < 8; i++) bitq.push_back(word[i]);
      go <= 1;
      repeat (260) @(posedge i_clock);
      dp_oe <= 1;
      dp_out <= rnd[8];
      repeat (270) @(posedge i_clock);
      {go, dp_oe} <= 0;
      chk(seen, {8{rnd[8]}});
      chk(bitq.size(), 0);
      chk(dp_clk, 0);
      bus(1, `DPLE_OFF_CONTROL, 32'h2, 0);
      halted <= 1;
      repeat (4) @(posedge i_clock);
      chk({wd_run, gt_run, ta_run, p_run}, 4'b0001);
      bus(1, `DPLE_OFF_CONTROL, 32'h0, 0);
      repeat (4) @(posedge i_clock);
      chk({wd_run, gt_run, ta_run, p_run}, 4'b0111);
      halted <= 0;
      pin_rst(0);
      lock_n <= 1;
      bus(0, `DPLE_OFF_MONITOR, 0, 1);
      bus(1, `DPLE_OFF_CLK_PORT, 32'h16, 0);
      repeat (4) @(posedge i_clock);
      chk({clk_oe, gp_cin}, 0);
      bus(1, `DPLE_OFF_CONTROL, 32'h1, 0);
      repeat (12) @(posedge i_clock);
      bus(0, `DPLE_OFF_MONITOR, 0, 1);
      pin_rst(1);
      lock_n <= 0;
      repeat (8) @(posedge i_clock);
      bus(0, `DPLE_OFF_MONITOR, 0, 0);
      results;
   end
endmodule // debug_pin_enable_latch_tb
`default_nettype wire

// *** dple_consts.vh ***
// constants for the debug pin enable latch block
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef DPLE_CONSTS_VH
`define DPLE_CONSTS_VH
`define DPLE_PERIPH_BASE 32'h41FFF000
`define DPLE_ADDR_W 8
`define DPLE_OFF_MONITOR 8'h5C
`define DPLE_OFF_CLK_PORT 8'h00
`define DPLE_OFF_DIO_PORT 8'h04
`define DPLE_OFF_CONTROL 8'h08
`define DPLE_OFF_STATUS 8'h0C
// port setting field positions
`define DPLE_BIT_FUNC 0
`define DPLE_BIT_IE 1
`define DPLE_BIT_OE 2
`define DPLE_BIT_PU 3
`define DPLE_BIT_PD 4
// reset port settings: {pd,pu,oe,ie,func}
`define DPLE_CLK_PORT_RST 5'h13
`define DPLE_DIO_PORT_RST 5'h0F
// control field positions
`define DPLE_BIT_SYSRST 0
`define DPLE_BIT_TMR_STOP 1
`define DPLE_SYSRST_CYCLES 4'h8
`define DPLE_RD_DEFAULT 32'h00000000
`endif

// *** dple_probe.sv ***
// serial debug probe: one write byte then one read byte
// assumes the bench resolves the shared data wire
`timescale 1ns/1ps
`default_nettype none
module dple_probe (
   // control
   input wire logic i_go,
   input wire logic [7:0] i_word,
   // data wire
   input wire logic i_dio,
   output logic o_clk,
   output logic o_dio,
   output logic o_dio_oe,
   output logic [7:0] o_seen
);
   initial begin
      o_clk = 0;
      o_dio = 0;
      o_dio_oe = 0;
      o_seen = 0;
   end
   // clock stands low outside frames, 160 ns period
   always @(posedge i_go) begin
      #3;
      o_dio_oe = 1;
      for (int i = 0; i < 8; i++) begin
         o_dio = i_word[i];
         #80 o_clk = 1;
         #80 o_clk = 0;
      end
      o_dio_oe = 0;
      for (int i = 0; i < 8; i++) begin
         #80 o_clk = 1;
         o_seen[i] = i_dio;
         #80 o_clk = 0;
      end
   end
endmodule // dple_probe
`default_nettype wire

// *** dple_sva.sv ***
// checker: bus handshake, quiet reset, halt gating, reset pulse
// assumes it is bound onto dple_top
`timescale 1ns/1ps
`default_nettype none
module dple_sva (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // bus
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [7:0] i_avs_address,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // pins and run enables
   input wire logic o_swd_dio_oe,
   input wire logic o_swd_clk_oe,
   input wire logic o_dp_clk_rise,
   input wire logic o_system_reset,
   input wire logic i_core_halted,
   input wire logic o_watchdog_timer_run,
   input wire logic o_peripheral_run
);
   wire req = i_avs_read | i_avs_write;
   sequence sysrst_hold;
      o_system_reset [*8];
   endsequence
   sequence sysrst_end;
      sysrst_hold ##1 !o_system_reset;
   endsequence
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wait_ack_a: assert property (req && o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest)
      else $error("bus request not answered");
   wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (!o_avs_waitrequest |-> $past(req))
      else $error("ack without request");
   rd_idle_a: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h00000000)
      else $error("read data outside ack");
   mon_zero_a: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == 8'h5C
      |-> o_avs_readdata[31:1] == 31'h00000000)
      else $error("monitor upper bits set");
   rst_quiet_a: assert property (disable iff (1'b0)
      i_rst |-> !o_swd_dio_oe && !o_swd_clk_oe && !o_dp_clk_rise)
      else $error("pin activity in reset");
   wdog_halt_a: assert property (i_core_halted ##1 i_core_halted ##1 i_core_halted
      |-> !o_watchdog_timer_run)
      else $error("watchdog runs in halt");
   periph_run_a: assert property (o_peripheral_run)
      else $error("peripherals stopped");
   sysrst_len_a: assert property ($rose(o_system_reset) |-> sysrst_end)
      else $error("system reset length wrong");
   dp_pulse_a: assert property (o_dp_clk_rise |=> !o_dp_clk_rise)
      else $error("clock rise pulse too long");
endmodule // dple_sva
bind dple_top dple_sva u_sva (.i_clock(i_clock), .i_rst(i_rst), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .i_avs_address(i_avs_address),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_swd_dio_oe(o_swd_dio_oe), .o_swd_clk_oe(o_swd_clk_oe), .o_dp_clk_rise(o_dp_clk_rise),
   .o_system_reset(o_system_reset), .i_core_halted(i_core_halted),
   .o_watchdog_timer_run(o_watchdog_timer_run), .o_peripheral_run(o_peripheral_run));
`default_nettype wire

// *** dple_sync.v ***
// two-flop synchroniser for one level from outside the clock domain
// assumes nothing beyond a free-running clock
`timescale 1ns/1ps
`default_nettype none
module dple_sync (
   // clock and reset
   input wire i_clock,
   input wire i_rst,
   // level in and out
   input wire i_async,
   output wire o_sync
);
   reg meta_reg;
   reg sync_reg;
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end
   assign o_sync = sync_reg;
endmodule // dple_sync
`default_nettype wire

// *** dple_top.v ***
// debug pin enable latch: serial debug pin muxing, lock monitor, halt gating
// assumes avalon-mm master on i_clock; i_rst is the external pin reset
`timescale 1ns/1ps
`default_nettype none
`include "dple_consts.vh"
// Behaviour
// - The device offers a two-wire debug port with a clock input and a two-way data line.
// - After reset both debug pins are routed to the debug function.
// - Software may move either pin to port use unless the lock is set.
// - Reset port settings are clock pin 1,1,0,0,1 and data pin 1,1,1,1,0.
// - No debug transfer passes while the external reset is asserted.
// - Writing the system reset request bit starts a fresh system reset; the code ignores that write while a system reset is still running.
// - The active-low lock pin matters only just after reset release.
// - At reset release a low lock pin sets the lock and fixes both pins to debug.
// - The lock persists against software port changes until the next pin reset.
// - A read-only 32-bit lock monitor register sits at offset 0x5C.
// - Monitor bit 0 reads 1 when locked and 0 otherwise, other bits read zero.
// - Core debug halt stops the watchdog from counting.
// - During halt each 16-bit timer runs or stops per a software setting; the code runs or stops both timers together from one shared control bit.
// - Other peripherals keep running during halt.
module dple_top (
   // clock and reset
   input wire i_clock,
   input wire i_rst,
   // avalon-mm slave
   input wire [7:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // debug pins
   input wire i_debug_lock_pin_n,
   input wire i_swd_clk_pin,
   input wire i_swd_dio_pin,
   output reg o_swd_dio_pin,
   output reg o_swd_dio_oe,
   output reg o_swd_clk_pin,
   output reg o_swd_clk_oe,
   output reg o_clk_pull_up,
   output reg o_clk_pull_down,
   output reg o_dio_pull_up,
   output reg o_dio_pull_down,
   // debug port core side
   output reg o_dp_clk,
   output reg o_dp_clk_rise,
   output reg o_dp_dio_in,
   input wire i_dp_dio_out,
   input wire i_dp_dio_oe,
   // general-purpose port side
   input wire i_gp_clk_out,
   input wire i_gp_dio_out,
   output reg o_gp_clk_in,
   output reg o_gp_dio_in,
   // system reset and halt
   output reg o_system_reset,
   input wire i_core_halted,
   output reg o_watchdog_timer_run,
   output reg o_general_timer_run,
   output reg o_sixteen_bit_timer_a_run,
   output reg o_peripheral_run
);
   // port settings {pd,pu,oe,ie,func}
   reg [4:0] clk_port_reg;
   reg [4:0] dio_port_reg;
   reg [1:0] tmr_stop_reg;
   reg debug_pins_locked_reg;
   reg lock_sampled_reg;
   reg [3:0] sysrst_cnt_reg;
   reg ack_reg;
   reg clk_prev_reg;
   wire lock_sync;
   wire clk_sync;
   wire dio_sync;
   wire clk_func;
   wire dio_func;
   wire clk_ie;
   wire dio_ie;
   wire wr_acc;
   wire rd_acc;
   wire in_sysrst;

   dple_sync u_sync_lock (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_debug_lock_pin_n),
      .o_sync(lock_sync)
   );
   dple_sync u_sync_clk (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_swd_clk_pin),
      .o_sync(clk_sync)
   );
   dple_sync u_sync_dio (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_swd_dio_pin),
      .o_sync(dio_sync)
   );

   // lock forces debug function regardless of port registers
   assign clk_func = clk_port_reg[`DPLE_BIT_FUNC] | debug_pins_locked_reg;
   assign dio_func = dio_port_reg[`DPLE_BIT_FUNC] | debug_pins_locked_reg;
   assign clk_ie = clk_port_reg[`DPLE_BIT_IE] | debug_pins_locked_reg;
   assign dio_ie = dio_port_reg[`DPLE_BIT_IE] | debug_pins_locked_reg;
   assign in_sysrst = (sysrst_cnt_reg != 4'h0);

   // one wait cycle, then ack
   assign wr_acc = i_avs_write & ack_reg;
   assign rd_acc = i_avs_read & ack_reg;

   // lock capture: third clock edge after pin reset release
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lock_sampled_reg <= 1'b0;
      end else begin
         // sync flops reset to 0, so wait until they carry the pin level
         lock_sampled_reg <= 1'b1;
      end
   end

   // pin is sampled once, two flops after release; later changes ignored
   reg lock_wait_reg;
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lock_wait_reg <= 1'b0;
      end else begin
         lock_wait_reg <= lock_sampled_reg;
      end
   end

   reg lock_taken_reg;
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lock_taken_reg <= 1'b0;
      end else if (lock_wait_reg && !lock_taken_reg) begin
         lock_taken_reg <= 1'b1;
      end
   end

   // the lock register itself, set only once per pin reset
   reg lock_reg;
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lock_reg <= 1'b0;
      end else if (lock_wait_reg && !lock_taken_reg && !lock_sync) begin
         lock_reg <= 1'b1;
      end
   end

   always @* begin
      debug_pins_locked_reg = lock_reg;
   end

   // register writes and software reset request
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         clk_port_reg <= `DPLE_CLK_PORT_RST;
         dio_port_reg <= `DPLE_DIO_PORT_RST;
         tmr_stop_reg <= 2'h0;
         sysrst_cnt_reg <= 4'h0;
      end else begin
         if (in_sysrst) begin
            sysrst_cnt_reg <= sysrst_cnt_reg - 4'h1;
            // system reset restores port defaults but keeps the lock
            clk_port_reg <= `DPLE_CLK_PORT_RST;
            dio_port_reg <= `DPLE_DIO_PORT_RST;
            tmr_stop_reg <= 2'h0;
         end else if (wr_acc && i_avs_byteenable[0]) begin
            case (i_avs_address)
               `DPLE_OFF_CLK_PORT: begin
                  clk_port_reg <= i_avs_writedata[4:0];
               end
               `DPLE_OFF_DIO_PORT: begin
                  dio_port_reg <= i_avs_writedata[4:0];
               end
               `DPLE_OFF_CONTROL: begin
                  tmr_stop_reg <= {2{i_avs_writedata[`DPLE_BIT_TMR_STOP]}};
                  if (i_avs_writedata[`DPLE_BIT_SYSRST]) begin
                     sysrst_cnt_reg <= `DPLE_SYSRST_CYCLES;
                  end
               end
               default: begin
                  clk_port_reg <= clk_port_reg;
               end
            endcase
         end
      end
   end

   // bus handshake and read mux
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ack_reg <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= `DPLE_RD_DEFAULT;
      end else begin
         ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_reg);
         o_avs_readdata <= `DPLE_RD_DEFAULT;
         if (i_avs_read && !ack_reg) begin
            case (i_avs_address)
               `DPLE_OFF_MONITOR: begin
                  o_avs_readdata <= {31'h0, debug_pins_locked_reg};
               end
               `DPLE_OFF_CLK_PORT: begin
                  o_avs_readdata <= {27'h0, clk_port_reg};
               end
               `DPLE_OFF_DIO_PORT: begin
                  o_avs_readdata <= {27'h0, dio_port_reg};
               end
               `DPLE_OFF_CONTROL: begin
                  o_avs_readdata <= {30'h0, tmr_stop_reg[0], 1'b0};
               end
               `DPLE_OFF_STATUS: begin
                  o_avs_readdata <= {29'h0, i_core_halted, in_sysrst, clk_func & dio_func};
               end
               default: begin
                  o_avs_readdata <= `DPLE_RD_DEFAULT;
               end
            endcase
         end
      end
   end

   // pin muxing, debug port feed, halt gating
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         // debug port held idle during pin reset
         o_dp_clk <= 1'b0;
         o_dp_clk_rise <= 1'b0;
         o_dp_dio_in <= 1'b1;
         clk_prev_reg <= 1'b0;
         o_swd_dio_pin <= 1'b0;
         o_swd_dio_oe <= 1'b0;
         o_swd_clk_pin <= 1'b0;
         o_swd_clk_oe <= 1'b0;
         o_clk_pull_up <= 1'b0;
         o_clk_pull_down <= 1'b1;
         o_dio_pull_up <= 1'b1;
         o_dio_pull_down <= 1'b0;
         o_gp_clk_in <= 1'b0;
         o_gp_dio_in <= 1'b0;
         o_system_reset <= 1'b0;
         o_watchdog_timer_run <= 1'b1;
         o_general_timer_run <= 1'b1;
         o_sixteen_bit_timer_a_run <= 1'b1;
         o_peripheral_run <= 1'b1;
      end else begin
         clk_prev_reg <= clk_sync;
         // debug clock pin is input only in debug function
         o_dp_clk <= clk_func & clk_ie & clk_sync;
         o_dp_clk_rise <= clk_func & clk_ie & clk_sync & ~clk_prev_reg;
         o_dp_dio_in <= dio_func ? (dio_ie & dio_sync) : 1'b1;
         o_swd_dio_pin <= dio_func ? i_dp_dio_out : i_gp_dio_out;
         o_swd_dio_oe <= dio_func ? (i_dp_dio_oe & dio_port_reg[`DPLE_BIT_OE])
                                  : dio_port_reg[`DPLE_BIT_OE];
         o_swd_clk_pin <= clk_func ? 1'b0 : i_gp_clk_out;
         o_swd_clk_oe <= clk_func ? 1'b0 : clk_port_reg[`DPLE_BIT_OE];
         o_clk_pull_up <= clk_port_reg[`DPLE_BIT_PU];
         o_clk_pull_down <= clk_port_reg[`DPLE_BIT_PD];
         o_dio_pull_up <= dio_port_reg[`DPLE_BIT_PU];
         o_dio_pull_down <= dio_port_reg[`DPLE_BIT_PD];
         o_gp_clk_in <= ~clk_func & clk_port_reg[`DPLE_BIT_IE] & clk_sync;
         o_gp_dio_in <= ~dio_func & dio_port_reg[`DPLE_BIT_IE] & dio_sync;
         o_system_reset <= in_sysrst;
         o_watchdog_timer_run <= ~i_core_halted;
         o_general_timer_run <= ~(i_core_halted & tmr_stop_reg[0]);
         o_sixteen_bit_timer_a_run <= ~(i_core_halted & tmr_stop_reg[1]);
         o_peripheral_run <= 1'b1;
      end
   end
endmodule // dple_top
`default_nettype wire
